// [verilog/bls_regs.svh]
`ifndef BLS_REGS_SVH
`define BLS_REGS_SVH
// clock and link rates
`define BLS_MCLK_HZ 25000000
`define BLS_SPI_HZ 12000000
`define BLS_TWI_HZ 100000
`define BLS_PROBE_MS 6
`define BLS_UART_BAUD 115200
// vector matching
`define BLS_COND_ALWAYS 4'he
`define BLS_REG_PC 4'hf
`define BLS_VEC_COUNT 8
`define BLS_VEC_SIZE 6
`define BLS_BLOCK_BYTES 512
`define BLS_BLK_LSB 0
`define BLS_NPG_LSB 13
`define BLS_PSZ_LSB 17
// xmodem framing
`define BLS_XM_SOH 8'h01
`define BLS_XM_INVITE 8'h43
`define BLS_XM_DATA 128
`define BLS_XM_FIRST_BLK 8'h01
`define BLS_CRC_POLY 16'h1021
// memory map
`define BLS_SRAM_BASE 32'h0020_0000
`define BLS_ROM_HIGH 32'h0010_0000
`define BLS_RESERVE_BYTES 3072
`define BLS_USB_HZ 48000000
`endif

// [verilog/bls_pkg.sv]
package bls_pkg;
  typedef enum logic [1:0] {bls_src_spi, bls_src_twi, bls_src_par, bls_src_none} bls_src_t;
  typedef enum logic [1:0] {bls_dfu_enum, bls_dfu_reconf, bls_dfu_xfer, bls_dfu_manif} bls_dfu_t;
endpackage

// [verilog/bls_seq.sv]
`include "bls_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module bls_seq #(
  parameter bit HAS_EXT_BUS = 1'b1,
  parameter int SRAM_BYTES = 98304,
  parameter int PROBE_CYC = `BLS_PROBE_MS * (`BLS_MCLK_HZ / 1000)
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [5:0] osc_code,
  input wire logic src_ack,
  input wire logic [1:0] src_sel,
  input wire logic [31:0] src_word,
  input wire logic src_word_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic out_ready,
  input wire logic dfu_step,
  output logic [7:0] pll_mul,
  output logic pll_go,
  output logic [3:0] spi_div,
  output logic [7:0] twi_div,
  output logic pins_oe,
  output logic [1:0] probe_src,
  output logic [6:0] twi_addr,
  output logic [7:0] blocks,
  output logic [3:0] page_log2,
  output logic [14:0] page_size,
  output logic uart_on,
  output logic [7:0] uart_div,
  output logic dfu_on,
  output logic [1:0] dfu_state,
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic [7:0] out_byte,
  output logic out_valid,
  output logic [31:0] wr_addr,
  output logic irq_off,
  output logic remapped,
  output logic [31:0] pc,
  output logic too_big
);
  typedef enum logic [2:0] {s_pll, s_probe, s_check, s_copy, s_upload, s_release,
    s_remap, s_run} bls_state_t;
  bls_state_t st;
  logic [1:0] rs;
  logic rst_s;
  logic [3:0] vec_idx;
  logic vec_bad;
  logic [31:0] probe_cnt;
  logic [7:0] xb [0:132];
  logic [7:0] x_idx;
  logic [7:0] blk_num;
  logic [15:0] crc;
  logic [1:0] buf_cnt;
  logic [7:0] buf0, buf1;
  logic in_ok;

  // branch or pc-relative load with always condition
  function automatic logic bls_vec_ok(input logic [31:0] w);
    logic br, ld;
    br = w[27:24] == 4'ha;
    ld = w[27:26] == 2'b01 && w[24] && w[21] && w[20] &&
      w[19:16] == `BLS_REG_PC && w[15:12] == `BLS_REG_PC;
    return w[31:28] == `BLS_COND_ALWAYS && (br || ld);
  endfunction

  function automatic logic [15:0] bls_crc(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `BLS_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) rs <= 2'b00;
    else rs <= {rs[0], 1'b1};
  end
  assign rst_s = rs[1];

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  always_ff @(posedge mclk or negedge rst_s) begin
    if (!rst_s) begin
      st <= s_pll;
      pll_go <= 1'b0;
      pll_mul <= 8'h00;
      probe_src <= bls_pkg::bls_src_spi;
      vec_idx <= 4'h0;
      vec_bad <= 1'b0;
      probe_cnt <= 32'h0;
      pins_oe <= 1'b0;
      blocks <= 8'h00;
      page_log2 <= 4'h0;
      page_size <= 15'h0000;
      uart_on <= 1'b0;
      dfu_on <= 1'b0;
      irq_off <= 1'b0;
      remapped <= 1'b0;
      pc <= `BLS_ROM_HIGH;
    end else begin
      case (st)
        s_pll: begin
          // table index stands for one listed crystal; others leave pll idle
          pll_go <= osc_code < 6'd34;
          pll_mul <= (osc_code < 6'd34) ? 8'(osc_code) + 8'h01 : 8'h00;
          st <= s_probe;
          pins_oe <= 1'b1;
        end
        s_probe: begin
          probe_cnt <= probe_cnt + 32'h1;
          if (src_word_valid && src_sel == probe_src) begin
            if (probe_src == bls_pkg::bls_src_twi && !src_ack) begin
              probe_src <= HAS_EXT_BUS ? bls_pkg::bls_src_par : bls_pkg::bls_src_none;
              vec_idx <= 4'h0;
            end else begin
              // vector six carries the size word, so it is exempt from matching
              vec_bad <= vec_bad | (vec_idx != 4'(`BLS_VEC_SIZE) &&
                !bls_vec_ok(src_word));
              if (vec_idx == 4'(`BLS_VEC_SIZE)) begin
                blocks <= src_word[`BLS_BLK_LSB +: 8];
                if (probe_src == bls_pkg::bls_src_spi) begin
                  page_log2 <= src_word[`BLS_NPG_LSB +: 4];
                  page_size <= src_word[`BLS_PSZ_LSB +: 15];
                end
              end
              vec_idx <= vec_idx + 4'h1;
              if (vec_idx == 4'(`BLS_VEC_COUNT - 1)) st <= s_check;
            end
          end else if (probe_src == bls_pkg::bls_src_none || probe_cnt >= 32'(PROBE_CYC)) begin
            st <= s_upload;
          end
        end
        s_check: begin
          vec_idx <= 4'h0;
          vec_bad <= 1'b0;
          if (!vec_bad) st <= s_copy;
          else begin
            st <= s_probe;
            // fixed probe order
            case (probe_src)
              bls_pkg::bls_src_spi: probe_src <= bls_pkg::bls_src_twi;
              bls_pkg::bls_src_twi: probe_src <= HAS_EXT_BUS ? bls_pkg::bls_src_par
                : bls_pkg::bls_src_none;
              default: probe_src <= bls_pkg::bls_src_none;
            endcase
          end
        end
        s_copy: if (src_word_valid && src_sel == bls_pkg::bls_src_none) st <= s_release;
        s_upload: begin
          uart_on <= 1'b1;
          dfu_on <= 1'b1;
          if (dfu_state == bls_pkg::bls_dfu_manif && dfu_step) st <= s_release;
        end
        s_release: begin
          pins_oe <= 1'b0;
          uart_on <= 1'b0;
          dfu_on <= 1'b0;
          irq_off <= 1'b1;
          st <= s_remap;
        end
        s_remap: begin
          remapped <= 1'b1;
          st <= s_run;
        end
        s_run: pc <= 32'h0;
        default: st <= s_pll;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fixed rates and fixed eeprom address
  always_ff @(posedge mclk or negedge rst_s) begin
    if (!rst_s) begin
      spi_div <= 4'h0;
      twi_div <= 8'h00;
      uart_div <= 8'h00;
      twi_addr <= 7'h00;
    end else begin
      // spi and twi rounded up so neither link exceeds its rate; uart rounds down
      spi_div <= 4'((`BLS_MCLK_HZ + `BLS_SPI_HZ - 1) / `BLS_SPI_HZ);
      twi_div <= 8'((`BLS_MCLK_HZ + `BLS_TWI_HZ - 1) / `BLS_TWI_HZ);
      uart_div <= 8'(`BLS_MCLK_HZ / (16 * `BLS_UART_BAUD));
      twi_addr <= 7'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // xmodem receive: invite, frame, crc, block number
  assign in_ok = buf_cnt != 2'd2;
  always_ff @(posedge mclk or negedge rst_s) begin
    if (!rst_s) begin
      tx_valid <= 1'b0;
      tx_byte <= 8'h00;
      x_idx <= 8'h00;
      blk_num <= `BLS_XM_FIRST_BLK;
      crc <= 16'h0000;
      too_big <= 1'b0;
      wr_addr <= `BLS_SRAM_BASE;
    end else begin
      tx_valid <= st == s_upload && x_idx == 8'h00 && !rx_valid;
      tx_byte <= `BLS_XM_INVITE;
      if (st == s_upload && rx_valid && in_ok) begin
        xb[x_idx] <= rx_byte;
        if (x_idx == 8'h00 && rx_byte != `BLS_XM_SOH) x_idx <= 8'h00;
        else if (x_idx == 8'(`BLS_XM_DATA + 4)) begin
          x_idx <= 8'h00;
          crc <= 16'h0000;
          // block number advances only when number, complement and crc all match
          if (xb[1] == blk_num && xb[2] == ~blk_num &&
              {xb[3 + `BLS_XM_DATA], rx_byte} == crc) begin
            blk_num <= blk_num + 8'h01;
          end
        end else begin
          // the two crc bytes themselves stay out of the sum
          if (x_idx >= 8'h03 && x_idx < 8'(3 + `BLS_XM_DATA)) begin
            crc <= bls_crc(crc, rx_byte);
          end
          x_idx <= x_idx + 8'h01;
        end
      end
      if (out_valid && out_ready) begin
        wr_addr <= wr_addr + 32'h1;
        too_big <= too_big | (wr_addr - `BLS_SRAM_BASE >=
          32'(SRAM_BYTES - `BLS_RESERVE_BYTES - 1)); // reaching the limit is too big
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry skid buffer for received data bytes
  always_ff @(posedge mclk or negedge rst_s) begin
    if (!rst_s) begin
      buf_cnt <= 2'd0;
      buf0 <= 8'h00;
      buf1 <= 8'h00;
      out_valid <= 1'b0;
    end else begin
      if (st == s_upload && rx_valid && in_ok && x_idx >= 8'h03 &&
          x_idx < 8'(3 + `BLS_XM_DATA)) begin
        if (buf_cnt == 2'd0 || (buf_cnt == 2'd1 && out_ready)) buf0 <= rx_byte;
        else buf1 <= rx_byte;
        buf_cnt <= (buf_cnt == 2'd1 && out_ready) ? 2'd1 : buf_cnt + 2'd1;
        out_valid <= 1'b1;
      end else if (buf_cnt != 2'd0 && out_ready) begin
        buf0 <= buf1;
        buf_cnt <= buf_cnt - 2'd1;
        out_valid <= buf_cnt != 2'd1; // registered copy of a non-empty buffer
      end
    end
  end
  assign out_byte = buf0;

  ////////////////////////////////////////////////////////////////////////////
  // dfu phase tracking
  always_ff @(posedge mclk or negedge rst_s) begin
    if (!rst_s) dfu_state <= bls_pkg::bls_dfu_enum;
    else if (dfu_on && dfu_step && dfu_state != bls_pkg::bls_dfu_manif)
      dfu_state <= bls_pkg::bls_dfu_t'(dfu_state + 2'd1);
  end

  ////////////////////////////////////////////////////////////////////////////
  a_remap_order: assert property (@(posedge mclk) disable iff (!rst_s)
    $rose(remapped) |-> irq_off && !pins_oe) else $error("remap before release");
  a_jump_zero: assert property (@(posedge mclk) disable iff (!rst_s)
    $rose(remapped) |=> ##1 pc == 32'h0) else $error("no jump to zero");
  a_invite_char: assert property (@(posedge mclk) disable iff (!rst_s)
    tx_valid |-> tx_byte == 8'h43) else $error("wrong invite");
  a_eeprom_addr: assert property (@(posedge mclk) disable iff (!rst_s)
    twi_addr == 7'h00) else $error("eeprom address");
  a_upload_ports: assert property (@(posedge mclk) disable iff (!rst_s)
    st == s_upload |=> uart_on && dfu_on) else $error("uploader off");
  a_no_par: assert property (@(posedge mclk) disable iff (!rst_s)
    !HAS_EXT_BUS |-> probe_src != bls_pkg::bls_src_par) else $error("parallel probed");
  a_pll_first: assert property (@(posedge mclk) disable iff (!rst_s)
    pins_oe && !remapped |-> $past(st) != s_pll || pll_go || pll_mul == 8'h00)
    else $error("pll skipped");
  a_blk_step: assert property (@(posedge mclk) disable iff (!rst_s)
    blk_num != $past(blk_num) |-> blk_num == 8'($past(blk_num) + 8'h01))
    else $error("block number step");
  c_upload: cover property (@(posedge mclk) st == s_upload);
  c_copy: cover property (@(posedge mclk) st == s_copy);
  c_block: cover property (@(posedge mclk) blk_num == 8'h02);
endmodule
`default_nettype wire

// [testbench/bls_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
// boot memories: one image shared by all sources, zeroed where valid_mask is clear; GAP sets how slowly words arrive
module bls_mem_model #(
  parameter int GAP = 2
) (
  input wire logic mclk,
  input wire logic [1:0] probe_src,
  input wire logic pins_oe,
  input wire logic [6:0] twi_addr,
  input wire logic [3:0] valid_mask,
  input wire logic done_req,
  output logic src_ack,
  output logic [1:0] src_sel,
  output logic [31:0] src_word,
  output var logic src_word_valid
);
  logic [31:0] img [8];
  logic [1:0] last_src = 2'h3;
  int idx = 8;
  int gap = 0;
  initial begin
    img = '{32'hea00000b, 32'he5bff014, 32'he5bff014, 32'he5bff014, 32'he5bff014,
      32'he53fff20, 32'h0841a017, 32'he53fff20};
    src_sel = 2'h0;
    src_word = 32'h0;
    src_word_valid = 1'b0;
  end
  // eeprom answers only when addressed at zero and present
  assign src_ack = pins_oe && probe_src == 2'h1 && twi_addr == 7'h00 && valid_mask[1];
  //////////////////////////////////////////////////////////////////////
  // eight vectors per source; word lines toggle when nothing is offered
  always @(posedge mclk) begin
    src_word_valid <= 1'b0;
    src_word <= ~src_word;
    if (!pins_oe) last_src <= 2'h3;
    if (done_req) begin
      src_sel <= 2'h3;
      src_word_valid <= 1'b1;
    end else if (pins_oe && probe_src != last_src) begin
      last_src <= probe_src;
      idx <= 0;
      gap <= GAP;
    end else if (gap > 0) begin
      gap <= gap - 1;
    // an unacked eeprom read still ends, just with src_ack low
    end else if (idx < 8 && pins_oe && probe_src != 2'h3) begin
      src_sel <= probe_src;
      src_word <= valid_mask[probe_src] ? img[idx] : 32'h0;
      src_word_valid <= 1'b1;
      idx <= idx + 1;
      gap <= GAP;
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_bls_seq.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_bls_seq;
  logic mclk, rst_b, src_ack, src_word_valid, rx_valid, out_ready, dfu_step, done_req;
  logic pll_go, pins_oe, uart_on, dfu_on, tx_valid, out_valid, irq_off, remapped, too_big;
  logic [1:0] src_sel, probe_src, dfu_state;
  logic [3:0] spi_div, page_log2, valid_mask;
  logic [5:0] osc_code;
  logic [6:0] twi_addr;
  logic [7:0] rx_byte, pll_mul, twi_div, blocks, uart_div, tx_byte, out_byte;
  logic [14:0] page_size;
  logic [31:0] src_word, wr_addr, pc, first_addr;
  logic [7:0] got[$];
  int errors, num_checks;
  bls_seq #(.SRAM_BYTES(3328), .PROBE_CYC(100)) u_bls_seq (
    .mclk(mclk), .rst_b(rst_b), .osc_code(osc_code), .src_ack(src_ack), .src_sel(src_sel),
    .src_word(src_word), .src_word_valid(src_word_valid), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .out_ready(out_ready), .dfu_step(dfu_step), .pll_mul(pll_mul),
    .pll_go(pll_go), .spi_div(spi_div), .twi_div(twi_div), .pins_oe(pins_oe),
    .probe_src(probe_src), .twi_addr(twi_addr), .blocks(blocks), .page_log2(page_log2),
    .page_size(page_size), .uart_on(uart_on), .uart_div(uart_div), .dfu_on(dfu_on),
    .dfu_state(dfu_state), .tx_valid(tx_valid), .tx_byte(tx_byte), .out_byte(out_byte),
    .out_valid(out_valid), .wr_addr(wr_addr), .irq_off(irq_off), .remapped(remapped),
    .pc(pc), .too_big(too_big));
  bls_mem_model u_bls_mem_model (
    .mclk(mclk), .probe_src(probe_src), .pins_oe(pins_oe), .twi_addr(twi_addr),
    .valid_mask(valid_mask), .done_req(done_req), .src_ack(src_ack), .src_sel(src_sel),
    .src_word(src_word), .src_word_valid(src_word_valid));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // sram sink: keep every byte the buffer hands over
  always @(posedge mclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (got.size() == 0) first_addr <= wr_addr;
      got.push_back(out_byte);
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] v, input logic [31:0] e, input string m);
    num_checks++;
    if (v !== e) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, v, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic bit cond(input int c);
    case (c)
      0: return pll_go === 1'b1;
      1: return probe_src === 2'h1;
      2: return probe_src === 2'h2;
      3: return tx_valid === 1'b1;
      4: return blocks !== 8'h00;
      5: return remapped === 1'b1;
      default: return got.size() >= 128;
    endcase
  endfunction
  // sample 1 ns after the edge so registered outputs have settled
  task automatic wait_for(input int c);
    int n;
    for (n = 0; n < 400 && !cond(c); n++) begin
      @(posedge mclk);
      #1;
    end
    if (n == 400) begin
      errors++;
      $display("ERROR %0t wait %0d timed out", $time, c);
      final_report();
    end
  endtask
  task automatic do_reset();
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic send_byte(input logic [7:0] b);
    @(posedge mclk);
    rx_byte <= b;
    rx_valid <= 1'b1;
    @(posedge mclk);
    rx_valid <= 1'b0;
    @(posedge mclk);
  endtask
  // sink stalls over two data bytes so the buffer fills
  task automatic send_block(input logic [7:0] n);
    logic [15:0] crc;
    logic [7:0] d;
    crc = 16'h0000;
    got.delete();
    out_ready <= 1'b0;
    send_byte(8'h01);
    send_byte(n);
    send_byte(~n);
    for (int i = 0; i < 128; i++) begin
      d = 8'(i * 7) ^ n;
      send_byte(d);
      if (i == 1) out_ready <= 1'b1;
      crc = crc ^ {d, 8'h00};
      repeat (8) crc = crc[15] ? {crc[14:0], 1'b0} ^ 16'h1021 : {crc[14:0], 1'b0};
    end
    send_byte(crc[15:8]);
    send_byte(crc[7:0]);
    wait_for(6);
    for (int i = 0; i < 128; i++) chk(32'(got[i]), 32'(8'(i * 7) ^ n), "data");
  endtask
  //////////////////////////////////////////////////////////////////////
  // run one boots from flash, run two falls back to the uploader
  initial begin
    errors = 0;
    num_checks = 0;
    rst_b = 1'b0;
    osc_code = 6'h05;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    out_ready = 1'b1;
    dfu_step = 1'b0;
    done_req = 1'b0;
    valid_mask = 4'h1;
    do_reset();
    chk(pc, 32'h0010_0000, "pc");
    wait_for(0);
    chk(32'(pll_mul), 32'h6, "pll");
    wait_for(4);
    chk(32'(probe_src), 32'h0, "src");
    chk(32'(blocks), 32'h17, "blocks");
    chk(32'(page_log2), 32'hd, "pages");
    chk(32'(page_size), 32'd1056, "psize");
    chk(32'(pins_oe), 32'h1, "pins");
    chk(32'(spi_div), 32'h3, "spi");
    chk(32'(twi_div), 32'd250, "twi");
    // let vector seven and the check cycle pass before ending the copy
    repeat (8) @(posedge mclk);
    done_req <= 1'b1;
    @(posedge mclk);
    done_req <= 1'b0;
    wait_for(5);
    chk(32'(irq_off), 32'h1, "irq");
    chk(32'(pins_oe), 32'h0, "pins");
    // the jump lands one cycle after the remap
    @(posedge mclk);
    #1;
    chk(pc, 32'h0, "jump");
    valid_mask <= 4'h0;
    do_reset();
    chk(wr_addr, 32'h0020_0000, "base");
    wait_for(1);
    chk(32'(twi_addr), 32'h0, "addr");
    wait_for(2);
    wait_for(3);
    chk(32'(tx_byte), 32'h43, "invite");
    chk(32'(uart_on & dfu_on), 32'h1, "upl");
    chk(32'(uart_div), 32'd13, "baud");
    send_block(8'h01);
    chk(first_addr, 32'h0020_0000, "dest");
    chk(32'(too_big), 32'h0, "size");
    send_block(8'h02);
    chk(32'(too_big), 32'h1, "size");
    for (int s = 0; s < 4; s++) begin
      chk(32'(dfu_state), 32'(s), "dfu");
      @(posedge mclk);
      dfu_step <= 1'b1;
      @(posedge mclk);
      dfu_step <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
    end
    wait_for(5);
    @(posedge mclk);
    #1;
    chk(pc, 32'h0, "jump");
    final_report();
  end
endmodule
`default_nettype wire
